// [hw/psw_cfg.svh]
// offsets, field positions, reset values and counts of the symbol monitor block
`ifndef PSW_CFG_SVH
`define PSW_CFG_SVH

`define PSW_ADDR_W        12
`define PSW_DATA_W        16
`define PSW_OFS_MON       12'h559
`define PSW_OFS_POL       12'h55B
`define PSW_OFS_OAM       12'h55C
`define PSW_OFS_STAT      12'h5F0
`define PSW_OFS_IRQ_ST    12'h5F1
`define PSW_OFS_IRQ_MSK   12'h5F2

`define PSW_RST_MON       7'h51
`define PSW_RST_POL       5'h00
`define PSW_RST_OAM       2'h0
`define PSW_RST_MSK       2'h0

`define PSW_MON_TH_LSB    0
`define PSW_MON_TH_MSB    3
`define PSW_MON_IEEE      4
`define PSW_MON_FEN       5
`define PSW_MON_FVAL      6
`define PSW_MON_W         7

`define PSW_POL_TXP       0
`define PSW_POL_TXO       1
`define PSW_POL_RXP       2
`define PSW_POL_RXO       3
`define PSW_POL_AUTO      4
`define PSW_POL_W         5

`define PSW_OAM_TX        0
`define PSW_OAM_RX        1
`define PSW_OAM_CW        2

`define PSW_STAT_LL       0
`define PSW_STAT_LIVE     1
`define PSW_IRQ_RISE      0
`define PSW_IRQ_FALL      1
`define PSW_IRQ_W         2

`define PSW_NSYM          7
`define PSW_OAM_W         8
`define PSW_WIN_WORDS     256

`endif

// [hw/psw_pkg.sv]
// types shared by the symbol monitor block
`include "psw_cfg.svh"
package psw_pkg;

    // ternary symbol, two's complement: 0, +1, -1
    typedef logic [1:0] psw_tern_t;

    localparam psw_tern_t PSW_SYM_ZERO  = 2'h0;
    localparam psw_tern_t PSW_SYM_PLUS  = 2'h1;
    localparam psw_tern_t PSW_SYM_MINUS = 2'h3;

    typedef struct packed {
        logic                            valid;
        psw_tern_t [`PSW_NSYM-1:0]       sym;
    } psw_sym_word_t;

    typedef struct packed {
        logic                            valid;
        logic [`PSW_OAM_W-1:0]           data;
    } psw_oam_beat_t;

    typedef enum logic [1:0] {
        PSW_MON_IDLE = 2'b00,
        PSW_MON_RUN  = 2'b01
    } psw_mon_state_t;

endpackage : psw_pkg

// [hw/psw_symbol_watchdog.sv]
// symbol monitor, symbol polarity and order, and oam crc bit order for the pcs
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`include "psw_cfg.svh"

// How it works
// [RL1] With forcing enabled the monitor status shows the force value, which resets to one while enable resets to zero.
// [RL2] A read-write force value bit holds the status shown whenever forcing is on.
// [RL3] With the standard enable bit set the monitor counters only run while the link is up.
// [RL4] Separate counters for 0, +1 and -1 symbols raise the status when any falls short of the threshold in a window.
// [RL5] With auto correction on and the device slave, transmit polarity follows the detected receive polarity.
// [RL6] With receive order inversion set, received symbols S0..S6 are taken as S6..S0.
// [RL7] With receive polarity inversion set, every received symbol is negated.
// [RL8] With transmit order inversion set, symbols S0..S6 go out as S6..S0, which the partner must undo.
// [RL9] With transmit polarity inversion set, every transmitted symbol is negated.
// [RL10] Data enters the receive crc checker lsb first with its bit at zero and msb first at one.
// [RL11] Data enters the transmit crc calculator lsb first with its bit at zero and msb first at one.
// [RL12] A latched-low bit reads zero once the monitor status was seen low, and re-arms when read.
// [RL13] Reserved bits read as zero and writes to them change nothing.
module psw_symbol_watchdog
    import psw_pkg::*;
#(
    parameter int WIN_WORDS = `PSW_WIN_WORDS
) (
    // clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rstn_i,
    // register port
    input  wire logic [`PSW_ADDR_W-1:0]    addr_i,
    input  wire logic [`PSW_DATA_W-1:0]    wdata_i,
    input  wire logic                      we_i,
    input  wire logic                      re_i,
    output logic      [`PSW_DATA_W-1:0]    rdata_o,
    // link state
    input  wire logic                      link_up_i,
    input  wire logic                      is_slave_i,
    input  wire logic                      rx_pol_det_i,
    // symbol streams
    input  wire psw_sym_word_t             rx_i,
    output psw_sym_word_t                  rx_o,
    input  wire psw_sym_word_t             tx_i,
    output psw_sym_word_t                  tx_o,
    // oam crc feeds
    input  wire psw_oam_beat_t             rx_oam_i,
    output psw_oam_beat_t                  rx_crc_o,
    input  wire psw_oam_beat_t             tx_oam_i,
    output psw_oam_beat_t                  tx_crc_o,
    // monitor and interrupt
    output logic                           mon_stat_o,
    output logic                           irq_o
);

    localparam int N   = `PSW_NSYM;
    localparam int WW  = $clog2(WIN_WORDS);
    localparam logic [WW-1:0] WIN_LAST = WW'(WIN_WORDS - 1);

    generate
        if (WIN_WORDS < 2 || WIN_WORDS > 65536) begin : g_bad_win
            $error("WIN_WORDS out of range");
        end
    endgenerate

    function automatic psw_tern_t neg_sym(input psw_tern_t s);
        return 2'(~s + 2'h1);
    endfunction : neg_sym

    function automatic logic [`PSW_OAM_W-1:0] bit_rev(input logic [`PSW_OAM_W-1:0] d);
        logic [`PSW_OAM_W-1:0] r;
        r = '0;
        for (int k = 0; k < `PSW_OAM_W; k++) begin
            r[k] = d[`PSW_OAM_W-1-k];
        end
        return r;
    endfunction : bit_rev

    function automatic logic [2:0] cnt_cls(input psw_tern_t [N-1:0] w, input psw_tern_t v);
        logic [2:0] n;
        n = 3'h0;
        for (int k = 0; k < N; k++) begin
            if (w[k] == v) begin
                n = 3'(n + 3'h1);
            end
        end
        return n;
    endfunction : cnt_cls

    // ---------------- registers
    logic [`PSW_MON_W-1:0]   mon_cfg_q;
    logic [`PSW_POL_W-1:0]   pol_cfg_q;
    logic [`PSW_OAM_CW-1:0]  oam_cfg_q;
    logic [`PSW_IRQ_W-1:0]   irq_st_q;
    logic [`PSW_IRQ_W-1:0]   irq_st_d;
    logic [`PSW_IRQ_W-1:0]   irq_msk_q;
    logic                    ll_q;
    logic                    mon_stat_q;
    logic                    mon_stat_d;
    logic                    raw_q;
    logic [`PSW_DATA_W-1:0]  rd_d;
    logic [`PSW_DATA_W-1:0]  rdata_q;
    logic                    irq_q;

    wire sel_mon  = (addr_i == `PSW_OFS_MON);
    wire sel_pol  = (addr_i == `PSW_OFS_POL);
    wire sel_oam  = (addr_i == `PSW_OFS_OAM);
    wire sel_stat = (addr_i == `PSW_OFS_STAT);
    wire sel_ist  = (addr_i == `PSW_OFS_IRQ_ST);
    wire sel_msk  = (addr_i == `PSW_OFS_IRQ_MSK);

    wire [3:0] mon_th  = mon_cfg_q[`PSW_MON_TH_MSB:`PSW_MON_TH_LSB];
    wire       ieee_en = mon_cfg_q[`PSW_MON_IEEE];
    wire       frc_en  = mon_cfg_q[`PSW_MON_FEN];
    wire       frc_val = mon_cfg_q[`PSW_MON_FVAL];

    // only the defined field bits are stored [RL13]
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            mon_cfg_q <= `PSW_RST_MON;
            pol_cfg_q <= `PSW_RST_POL;
            oam_cfg_q <= `PSW_RST_OAM;
            irq_msk_q <= `PSW_RST_MSK;
        end else if (we_i) begin
            if (sel_mon) mon_cfg_q <= wdata_i[`PSW_MON_W-1:0];     // [RL2]
            if (sel_pol) pol_cfg_q <= wdata_i[`PSW_POL_W-1:0];
            if (sel_oam) oam_cfg_q <= wdata_i[`PSW_OAM_CW-1:0];
            if (sel_msk) irq_msk_q <= wdata_i[`PSW_IRQ_W-1:0];
        end
    end

    // read decode, unmapped and reserved bits give zero
    always_comb begin
        rd_d = '0;
        if (sel_mon) begin
            rd_d[`PSW_MON_W-1:0] = mon_cfg_q;                        // [RL13]
        end else if (sel_pol) begin
            rd_d[`PSW_POL_W-1:0] = pol_cfg_q;
        end else if (sel_oam) begin
            rd_d[`PSW_OAM_CW-1:0] = oam_cfg_q;
        end else if (sel_stat) begin
            rd_d[`PSW_STAT_LL]   = ll_q;
            rd_d[`PSW_STAT_LIVE] = mon_stat_q;
        end else if (sel_ist) begin
            rd_d[`PSW_IRQ_W-1:0] = irq_st_q;
        end else if (sel_msk) begin
            rd_d[`PSW_IRQ_W-1:0] = irq_msk_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= re_i ? rd_d : '0;
        end
    end

    // ---------------- symbol datapath
    psw_tern_t [N-1:0] rx_fix;
    psw_tern_t [N-1:0] tx_fix;

    // slave follows detected rx polarity on top of the manual setting
    wire tx_pol_eff = pol_cfg_q[`PSW_POL_TXP] ^
                      (pol_cfg_q[`PSW_POL_AUTO] & is_slave_i & rx_pol_det_i);   // [RL5] [RL9]

    generate
        for (genvar i = 0; i < N; i++) begin : g_sym
            wire psw_tern_t rx_ord = pol_cfg_q[`PSW_POL_RXO] ? rx_i.sym[N-1-i] : rx_i.sym[i];  // [RL6]
            wire psw_tern_t tx_ord = pol_cfg_q[`PSW_POL_TXO] ? tx_i.sym[N-1-i] : tx_i.sym[i];  // [RL8]
            assign rx_fix[i] = pol_cfg_q[`PSW_POL_RXP] ? neg_sym(rx_ord) : rx_ord;           // [RL7]
            assign tx_fix[i] = tx_pol_eff ? neg_sym(tx_ord) : tx_ord;                        // [RL9]
        end
    endgenerate

    wire [`PSW_OAM_W-1:0] rx_crc_d = oam_cfg_q[`PSW_OAM_RX] ? bit_rev(rx_oam_i.data) : rx_oam_i.data; // [RL10]
    wire [`PSW_OAM_W-1:0] tx_crc_d = oam_cfg_q[`PSW_OAM_TX] ? bit_rev(tx_oam_i.data) : tx_oam_i.data; // [RL11]

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rx_o     <= '0;
            tx_o     <= '0;
            rx_crc_o <= '0;
            tx_crc_o <= '0;
        end else begin
            rx_o     <= '{valid: rx_i.valid, sym: rx_fix};
            tx_o     <= '{valid: tx_i.valid, sym: tx_fix};
            rx_crc_o <= '{valid: rx_oam_i.valid, data: rx_crc_d};
            tx_crc_o <= '{valid: tx_oam_i.valid, data: tx_crc_d};
        end
    end

    // ---------------- symbol monitor
    psw_mon_state_t st_q;
    logic [WW-1:0]  win_q;
    logic [2:0]     cls_short;

    // with the standard enable off the counters simply run free
    wire mon_go   = ieee_en ? link_up_i : 1'b1;                  // [RL3]
    wire run_ok   = (st_q == PSW_MON_RUN) && mon_go;
    wire mon_tick = run_ok && rx_i.valid;
    wire win_last = mon_tick && (win_q == WIN_LAST);

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_q <= PSW_MON_IDLE;
        end else begin
            case (st_q)
                PSW_MON_IDLE: if (mon_go) st_q <= PSW_MON_RUN;
                PSW_MON_RUN:  if (!mon_go) st_q <= PSW_MON_IDLE;
                default:      st_q <= PSW_MON_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i || !run_ok || win_last) begin
            win_q <= '0;                                         // [RL3]
        end else if (mon_tick) begin
            win_q <= WW'(win_q + 1'b1);
        end
    end

    // one saturating counter per symbol class: 0, +1, -1
    generate
        for (genvar c = 0; c < 3; c++) begin : g_cls
            localparam psw_tern_t CLS = (c == 0) ? PSW_SYM_ZERO : (c == 1) ? PSW_SYM_PLUS : PSW_SYM_MINUS;
            logic [3:0] cnt_q;
            wire  [4:0] sum   = {1'b0, cnt_q} + {2'b00, cnt_cls(rx_fix, CLS)};
            wire  [3:0] sat   = sum[4] ? 4'hF : sum[3:0];
            // the word closing the window still counts toward it
            assign cls_short[c] = (sat < mon_th);                    // [RL4]
            always_ff @(posedge mclk_i) begin
                if (!rstn_i || !run_ok || win_last) begin
                    cnt_q <= 4'h0;
                end else if (mon_tick) begin
                    cnt_q <= sat;                                    // [RL4]
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (!rstn_i || !run_ok) begin
            raw_q <= 1'b0;
        end else if (win_last) begin
            raw_q <= |cls_short;                                     // [RL4]
        end
    end

    assign mon_stat_d = frc_en ? frc_val : raw_q;                    // [RL1] [RL2]

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            mon_stat_q <= 1'b0;
        end else begin
            mon_stat_q <= mon_stat_d;
        end
    end
    assign mon_stat_o = mon_stat_q;

    // latch low wins over the re-arm of a read in the same cycle
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ll_q <= 1'b1;
        end else if (!mon_stat_q) begin
            ll_q <= 1'b0;                                            // [RL12]
        end else if (re_i && sel_stat) begin
            ll_q <= 1'b1;
        end
    end

    // ---------------- interrupts
    wire [`PSW_IRQ_W-1:0] ev  = {mon_stat_q & ~mon_stat_d, ~mon_stat_q & mon_stat_d};
    wire [`PSW_IRQ_W-1:0] w1c = (we_i && sel_ist) ? wdata_i[`PSW_IRQ_W-1:0] : '0;
    assign irq_st_d = ev | (irq_st_q & ~w1c);

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            irq_st_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            irq_q    <= |(irq_st_d & irq_msk_q);
        end
    end
    assign irq_o   = irq_q;
    assign rdata_o = rdata_q;

    // ---------------- assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_win_close;
        win_last ##0 (|cls_short) ##0 !frc_en;
    endsequence

    property p_force;
        frc_en |=> (mon_stat_q == $past(frc_val));
    endproperty
    a_force: assert property (p_force) else $error("forced status differs from force value"); // [RL1]

    property p_force_store;
        (we_i && sel_mon) |=> (frc_val == $past(wdata_i[`PSW_MON_FVAL])) && (frc_en == $past(wdata_i[`PSW_MON_FEN]));
    endproperty
    a_force_store: assert property (p_force_store) else $error("force value not stored"); // [RL2]

    property p_link_gate;
        (ieee_en && !link_up_i) |=> (win_q == '0) && !raw_q;
    endproperty
    a_link_gate: assert property (p_link_gate) else $error("monitor ran with link down"); // [RL3]

    property p_short_window;
        s_win_close ##1 (!frc_en && mon_go) |=> mon_stat_q;
    endproperty
    a_short_window: assert property (p_short_window) else $error("short window did not raise status"); // [RL4]

    property p_rx_pol;
        (pol_cfg_q[`PSW_POL_RXP] && !pol_cfg_q[`PSW_POL_RXO]) |=> (rx_o.sym[0] == neg_sym($past(rx_i.sym[0])));
    endproperty
    a_rx_pol: assert property (p_rx_pol) else $error("rx symbol not inverted"); // [RL7]

    property p_rx_order;
        (pol_cfg_q[`PSW_POL_RXO] && !pol_cfg_q[`PSW_POL_RXP]) |=> (rx_o.sym[0] == $past(rx_i.sym[N-1]));
    endproperty
    a_rx_order: assert property (p_rx_order) else $error("rx symbol order not reversed"); // [RL6]

    property p_tx_order;
        (pol_cfg_q[`PSW_POL_TXO] && !tx_pol_eff) |=> (tx_o.sym[N-1] == $past(tx_i.sym[0]));
    endproperty
    a_tx_order: assert property (p_tx_order) else $error("tx symbol order not reversed"); // [RL8]

    property p_tx_auto;
        (!pol_cfg_q[`PSW_POL_TXO] && !pol_cfg_q[`PSW_POL_TXP] &&
         pol_cfg_q[`PSW_POL_AUTO] && is_slave_i && rx_pol_det_i)
            |=> (tx_o.sym[0] == neg_sym($past(tx_i.sym[0])));
    endproperty
    a_tx_auto: assert property (p_tx_auto) else $error("slave tx polarity did not follow rx"); // [RL5]

    property p_tx_pol;
        (!pol_cfg_q[`PSW_POL_TXO] && pol_cfg_q[`PSW_POL_TXP] && !pol_cfg_q[`PSW_POL_AUTO])
            |=> (tx_o.sym[1] == neg_sym($past(tx_i.sym[1])));
    endproperty
    a_tx_pol: assert property (p_tx_pol) else $error("tx symbol not inverted"); // [RL9]

    property p_rx_crc;
        oam_cfg_q[`PSW_OAM_RX] |=> (rx_crc_o.data[0] == $past(rx_oam_i.data[`PSW_OAM_W-1]));
    endproperty
    a_rx_crc: assert property (p_rx_crc) else $error("rx crc data not msb first"); // [RL10]

    property p_tx_crc;
        !oam_cfg_q[`PSW_OAM_TX] |=> (tx_crc_o.data == $past(tx_oam_i.data));
    endproperty
    a_tx_crc: assert property (p_tx_crc) else $error("tx crc data not lsb first"); // [RL11]

    property p_low_latch;
        !mon_stat_q |=> !ll_q;
    endproperty
    a_low_latch: assert property (p_low_latch) else $error("low monitor status not latched"); // [RL12]

    property p_ll_rearm;
        (re_i && sel_stat && mon_stat_q) |=> ll_q;
    endproperty
    a_ll_rearm: assert property (p_ll_rearm) else $error("latched-low bit did not re-arm on read"); // [RL12]

    property p_reserved;
        (re_i && (sel_mon || sel_pol || sel_oam)) |=> (rdata_o[`PSW_DATA_W-1:`PSW_MON_W] == '0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // [RL13]

endmodule : psw_symbol_watchdog

// [verif/psw_link_partner.sv]
// behavioural link partner: sends random ternary symbol words toward the receiver
`timescale 1ns/1ns
`include "psw_cfg.svh"
module psw_link_partner
    import psw_pkg::*;
(
    // clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rstn_i,
    // bench control
    input  wire logic          starve_i,
    input  wire logic          rev_i,
    // line
    input  wire psw_sym_word_t line_i,
    output psw_sym_word_t      line_o
);
    localparam psw_tern_t SYMS [3] = '{PSW_SYM_ZERO, PSW_SYM_PLUS, PSW_SYM_MINUS};
    psw_sym_word_t w;

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            line_o <= '0;
        end else begin
            w.valid = 1'b1;
            for (int i = 0; i < `PSW_NSYM; i++) begin
                w.sym[i] = starve_i ? PSW_SYM_ZERO : SYMS[$urandom_range(2)];
            end
            // reversed send order is only sound when the far receiver reverses too
            for (int i = 0; i < `PSW_NSYM; i++) begin
                line_o.sym[i] <= rev_i ? w.sym[`PSW_NSYM-1-i] : w.sym[i];
            end
            line_o.valid <= w.valid;
        end
    end
endmodule : psw_link_partner

// [verif/test_pcs_symbol_watchdog_cfg.sv]
// self-checking bench for symbol monitor, symbol order and polarity, crc feed order
`timescale 1ns/1ns
`include "psw_cfg.svh"
module test_pcs_symbol_watchdog_cfg
    import psw_pkg::*;
;
    localparam int WIN = 4;
    logic                   mclk_i = 0, rstn_i = 0, we_i = 0, re_i = 0, starve = 0;
    logic                   link_up_i = 0, is_slave_i = 0, rx_pol_det_i = 0, mon_stat_o, irq_o;
    logic [`PSW_ADDR_W-1:0] addr_i = '0;
    logic [`PSW_DATA_W-1:0] wdata_i = '0, rdata_o;
    logic [4:0]             pcfg = '0;
    logic [1:0]             ocfg = '0;
    psw_sym_word_t          rx_i, rx_o, tx_o, prx, ptx, tx_i = '0;
    psw_oam_beat_t          rx_crc_o, tx_crc_o, pro, pto, rx_oam_i = '0, tx_oam_i = '0;
    int                     n_errors = 0, samples_checked = 0;

    psw_symbol_watchdog #(.WIN_WORDS(WIN)) DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .link_up_i(link_up_i),
        .is_slave_i(is_slave_i), .rx_pol_det_i(rx_pol_det_i), .rx_i(rx_i), .rx_o(rx_o), .tx_i(tx_i),
        .tx_o(tx_o), .rx_oam_i(rx_oam_i), .rx_crc_o(rx_crc_o), .tx_oam_i(tx_oam_i), .tx_crc_o(tx_crc_o),
        .mon_stat_o(mon_stat_o), .irq_o(irq_o));
    psw_link_partner lp (.mclk_i(mclk_i), .rstn_i(rstn_i), .starve_i(starve), .rev_i(pcfg[3]),
        .line_i(tx_o), .line_o(rx_i));

    always #5 mclk_i = ~mclk_i;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        we_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        re_i   <= 1'b0;
        #1;
        chk("rdata", rdata_o, exp);
    endtask : rd

    // bounded wait, the window length plus pipeline sets the reach
    task automatic wait_mon(input logic e);
        for (int i = 0; i < 40 && mon_stat_o !== e; i++) @(negedge mclk_i);
        chk("mon_stat", {15'h0, mon_stat_o}, {15'h0, e});
    endtask : wait_mon

    task automatic irq_is(input logic e);
        repeat (2) @(negedge mclk_i);
        chk("irq", {15'h0, irq_o}, {15'h0, e});
    endtask : irq_is

    function automatic psw_tern_t rt();
        int r = $urandom_range(2);
        return r == 0 ? PSW_SYM_ZERO : (r == 1 ? PSW_SYM_PLUS : PSW_SYM_MINUS);
    endfunction : rt

    function automatic psw_sym_word_t xsym(input psw_sym_word_t w, input logic rev, input logic inv);
        psw_sym_word_t o;
        o.valid = w.valid;
        for (int i = 0; i < `PSW_NSYM; i++) begin
            o.sym[i] = rev ? w.sym[`PSW_NSYM-1-i] : w.sym[i];
            o.sym[i] = inv ? psw_tern_t'(-o.sym[i]) : o.sym[i];
        end
        return o;
    endfunction : xsym

    function automatic psw_oam_beat_t xoam(input psw_oam_beat_t b, input logic rev);
        psw_oam_beat_t o;
        o.valid = b.valid;
        for (int k = 0; k < `PSW_OAM_W; k++) o.data[k] = rev ? b.data[`PSW_OAM_W-1-k] : b.data[k];
        return o;
    endfunction : xoam

    // outputs of this negedge belong to inputs stored at the previous one
    task automatic stream(input int n);
        psw_sym_word_t w;
        logic          tinv;
        for (int k = 0; k < n; k++) begin
            w.valid = 1'($urandom_range(1));
            for (int i = 0; i < `PSW_NSYM; i++) w.sym[i] = rt();
            @(posedge mclk_i);
            tx_i     <= w;
            rx_oam_i <= 9'($urandom);
            tx_oam_i <= 9'($urandom);
            @(negedge mclk_i);
            tinv = pcfg[0] ^ (pcfg[4] & is_slave_i & rx_pol_det_i);
            if (k > 0) begin
                chk("rx_o", {1'b0, rx_o}, {1'b0, xsym(prx, pcfg[3], pcfg[2])});
                chk("tx_o", {1'b0, tx_o}, {1'b0, xsym(ptx, pcfg[1], tinv)});
                chk("rx_crc", {7'h0, rx_crc_o}, {7'h0, xoam(pro, ocfg[1])});
                chk("tx_crc", {7'h0, tx_crc_o}, {7'h0, xoam(pto, ocfg[0])});
            end
            prx = rx_i;
            ptx = tx_i;
            pro = rx_oam_i;
            pto = tx_oam_i;
        end
    endtask : stream

    initial begin
        void'($urandom(87));
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd(`PSW_OFS_MON, 16'h0051);
        rd(`PSW_OFS_POL, 16'h0000);
        rd(`PSW_OFS_OAM, 16'h0000);
        rd(`PSW_OFS_IRQ_MSK, 16'h0000);
        rd(12'h123, 16'h0000);
        chk("mon_rst", {15'h0, mon_stat_o}, 16'h0000);
        wr(`PSW_OFS_MON, 16'hFFFF);
        rd(`PSW_OFS_MON, 16'h007F);
        wr(`PSW_OFS_POL, 16'hFFFF);
        rd(`PSW_OFS_POL, 16'h001F);
        wr(`PSW_OFS_OAM, 16'hFFFF);
        rd(`PSW_OFS_OAM, 16'h0003);
        for (int c = 0; c < 32; c++) begin
            @(posedge mclk_i);
            pcfg         <= 5'(c);
            ocfg         <= 2'(c);
            // slave with inverted rx detected is forced once so auto correction surely runs
            is_slave_i   <= (c == 16) | 1'($urandom_range(1));
            rx_pol_det_i <= (c == 16) | 1'($urandom_range(1));
            wr(`PSW_OFS_POL, 16'(c));
            wr(`PSW_OFS_OAM, 16'(c & 3));
            stream(6);
        end
        // link down: counters stay idle even with one symbol class only
        wr(`PSW_OFS_MON, 16'h0011);
        // forced status needs one more edge to drop
        @(posedge mclk_i);
        starve <= 1'b1;
        repeat (3 * WIN + 4) begin
            @(negedge mclk_i);
            chk("mon_idle", {15'h0, mon_stat_o}, 16'h0000);
        end
        @(posedge mclk_i);
        link_up_i <= 1'b1;
        wait_mon(1'b1);
        starve <= 1'b0;
        wait_mon(1'b0);
        wr(`PSW_OFS_MON, 16'h001F);
        wait_mon(1'b1);
        wr(`PSW_OFS_MON, 16'h0010);
        starve <= 1'b1;
        wait_mon(1'b0);
        wr(`PSW_OFS_IRQ_ST, 16'h0003);
        wr(`PSW_OFS_MON, 16'h0070);
        wait_mon(1'b1);
        rd(`PSW_OFS_MON, 16'h0070);
        rd(`PSW_OFS_STAT, 16'h0002);
        rd(`PSW_OFS_STAT, 16'h0003);
        irq_is(1'b0);
        wr(`PSW_OFS_IRQ_MSK, 16'h0001);
        irq_is(1'b1);
        wr(`PSW_OFS_IRQ_ST, 16'h0001);
        irq_is(1'b0);
        wr(`PSW_OFS_MON, 16'h0030);
        wait_mon(1'b0);
        rd(`PSW_OFS_STAT, 16'h0000);
        rd(`PSW_OFS_IRQ_ST, 16'h0002);
        wr(`PSW_OFS_IRQ_MSK, 16'h0002);
        irq_is(1'b1);
        wr(`PSW_OFS_IRQ_ST, 16'h0002);
        irq_is(1'b0);
        // standard enable off: counters run even with the link down
        @(posedge mclk_i);
        link_up_i <= 1'b0;
        wr(`PSW_OFS_MON, 16'h000F);
        wait_mon(1'b1);
        close_out();
    end

    // whole run is well under a thousand cycles
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule : test_pcs_symbol_watchdog_cfg
